/* File: mrr_host.sv */
`timescale 1ns/1ps
module mrr_host (
	// Resolved wire levels
	input  wire logic scl,
	input  wire logic sda,
	// Pulls toward low, high while pulling
	output logic      scl_pull,
	output logic      sda_pull
);
	// Phases stay above 1 us so the device has its read byte ready
	localparam int PHASE = 1300;
	localparam int HOLD  = 400;

	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end

	task automatic start_cond();
		wait (scl === 1'b1 && sda === 1'b1);
		#PHASE;
		sda_pull = 1'b1;
		#PHASE;
		scl_pull = 1'b1;
	endtask

	// Data moves only well after the clock fall, clear of the device hold
	task automatic bit_cycle(input logic drv, output logic seen);
		#HOLD;
		sda_pull = ~drv;
		#(PHASE - HOLD);
		scl_pull = 1'b0;
		#PHASE;
		seen = sda;
		scl_pull = 1'b1;
	endtask

	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(b[i], s);
		end
		bit_cycle(1'b1, s);
		ack = ~s;
	endtask

	task automatic get_byte(output logic [7:0] b, input logic last);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(1'b1, b[i]);
		end
		bit_cycle(last, s);
	endtask

	task automatic stop_cond();
		#HOLD;
		sda_pull = 1'b1;
		#(PHASE - HOLD);
		scl_pull = 1'b0;
		#PHASE;
		sda_pull = 1'b0;
		#PHASE;
	endtask
endmodule

/* File: mrr_pkg.sv */
package mrr_pkg;

	// Register offsets
	localparam logic [7:0] A_XL   = 8'h00;
	localparam logic [7:0] A_XH   = 8'h01;
	localparam logic [7:0] A_YL   = 8'h02;
	localparam logic [7:0] A_YH   = 8'h03;
	localparam logic [7:0] A_ZL   = 8'h04;
	localparam logic [7:0] A_ZH   = 8'h05;
	localparam logic [7:0] A_TEMP = 8'h06;
	localparam logic [7:0] A_STAT = 8'h07;
	localparam logic [7:0] A_CTL0 = 8'h08;
	localparam logic [7:0] A_CTL1 = 8'h09;
	localparam logic [7:0] A_CTL2 = 8'h0A;
	localparam logic [7:0] A_THX  = 8'h0B;
	localparam logic [7:0] A_THY  = 8'h0C;
	localparam logic [7:0] A_THZ  = 8'h0D;
	localparam logic [7:0] A_PID  = 8'h2F;

	// Status fields
	localparam int ST_MDONE  = 0;
	localparam int ST_TDONE  = 1;
	localparam int ST_MOTION = 2;
	localparam int ST_PUMP   = 3;
	localparam int ST_OTP    = 4;
	localparam logic [7:0] ST_RESET = 8'h00;

	// Control 0 fields: trigger bits read back as zero
	localparam int CT0_FIELD = 0;
	localparam int CT0_TEMP  = 1;
	localparam int CT0_MDT   = 2;
	localparam int CT0_OTP   = 6;
	localparam logic [7:0] CT0_TRIG_MASK = 8'h47;
	localparam logic [7:0] CTL_RESET     = 8'h00;

	// Control 2 field that enables the interrupt pin
	localparam int CT2_INT_EN = 6;

	// Bus framing
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [6:0] DEV_ADDR  = 7'h30;

	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mrr_req_s;

	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
		logic [7:0]  temp;
	} mrr_result_s;

	typedef struct packed {
		logic [7:0] ctl1;
		logic [7:0] ctl2;
		logic [7:0] thr_x;
		logic [7:0] thr_y;
		logic [7:0] thr_z;
	} mrr_cfg_s;

	typedef enum logic [3:0] {
		LK_IDLE, LK_ADDR, LK_ACK_AD, LK_PTR, LK_ACK_PTR,
		LK_WDATA, LK_ACK_WD, LK_RLOAD, LK_TX, LK_MACK
	} mrr_link_e;

endpackage

/* File: mrr_top.sv */
`timescale 1ns/1ps
// Summary of operation
// RQ1: A transfer starts only from an idle bus with both lines high, seen as data falling while clock is high; the code takes one in any state.
// RQ2: Both bus lines are open-drain wired AND, so the device only ever pulls the data line low or releases it.
// RQ3: Data is sampled while the clock is high and the device changes its data line only while the clock is low.
// RQ4: Axis results are 16-bit unsigned read-only values, low byte at the even and high byte at the odd address.
// RQ5: Temperature, status, three controls, three thresholds and the part identity are decoded at their offsets.
// RQ6: Temperature is an 8-bit unsigned read-only code, zero meaning minus 75 degrees at about 0.7 degrees a step.
// RQ7: Magnetic-done clears on a new measurement command and sets when that measurement finishes.
// RQ8: Temperature-done clears on a new measurement command and sets when that measurement finishes.
// RQ9: The host should see magnetic-done set before it reads the axis results.
// RQ10: Writing one to the magnetic-done, temperature-done or motion bit clears that bit's interrupt.
// RQ11: The motion bit sets whenever the motion detector reports an event.
// RQ12: Status bit 3 follows the charge pump on or off state.
// RQ13: Status bit 4 sets once the one-time memory has loaded, bits 7 to 5 read zero, and status resets to zero.
// RQ14: The device is a slave only, answers only its own address and never starts a transfer.
// RQ15: The interrupt pin is active high and stays released until the interrupt function is enabled.
// RQ16: Writing one to the field trigger in control 0 starts a measurement and the bit returns to zero by itself.
// RQ17: Undecoded addresses read zero and ignore writes.
module mrr_top #(
	parameter logic [7:0] PART_ID = 8'h5A // Arbitrary identity value
) (
	// Core clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	// Link sampling clock
	input  wire logic                 link_clk,
	// Bus pins
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe,
	// Interrupt pin
	output logic                      int_o,
	output logic                      int_oe,
	// Measurement core
	input  wire mrr_pkg::mrr_result_s result_i,
	input  wire logic                 field_done_i,
	input  wire logic                 temp_done_i,
	input  wire logic                 motion_evt_i,
	input  wire logic                 pump_on_i,
	input  wire logic                 otp_done_i,
	output logic                      field_sample_trigger,
	output logic                      temp_sample_trigger,
	output logic                      motion_start,
	output logic                      otp_reload,
	output mrr_pkg::mrr_cfg_s         cfg_o
);

	////////////////////////////////////////////////////////////////////////
	// Link domain: synchronisers

	logic              rst_m_ff, link_rst_ff;
	logic              scl_m_ff, scl_s_ff, scl_d_ff;
	logic              sda_m_ff, sda_s_ff, sda_d_ff;
	logic              ack_m_ff, ack_s_ff;
	logic              ack_tgl_ff;
	logic [7:0]        rd_data_ff;

	always_ff @(posedge link_clk) begin
		rst_m_ff    <= srst;
		link_rst_ff <= rst_m_ff;
		scl_m_ff    <= scl_i;
		scl_s_ff    <= scl_m_ff;
		scl_d_ff    <= scl_s_ff;
		sda_m_ff    <= sda_i;
		sda_s_ff    <= sda_m_ff;
		sda_d_ff    <= sda_s_ff;
		ack_m_ff    <= ack_tgl_ff;
		ack_s_ff    <= ack_m_ff;
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise  = scl_s_ff & ~scl_d_ff;
	assign scl_fall  = ~scl_s_ff & scl_d_ff;
	assign bus_start = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff; // RQ1
	assign bus_stop  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

	////////////////////////////////////////////////////////////////////////
	// Link domain: slave protocol

	mrr_pkg::mrr_link_e st_ff, nxt_st;
	logic [3:0]         cnt_ff, nxt_cnt;
	logic [7:0]         sh_ff, nxt_sh;
	logic [7:0]         tx_ff, nxt_tx;
	logic [7:0]         ptr_ff, nxt_ptr;
	logic               oe_ff, nxt_oe;
	logic               req_tgl_ff, nxt_req_tgl;
	mrr_pkg::mrr_req_s  req_ff, nxt_req;
	logic               rd_done;

	// Read data is only taken once the reply toggle has come back
	assign rd_done = (ack_s_ff == req_tgl_ff);

	always_comb begin
		nxt_st      = st_ff;
		nxt_cnt     = cnt_ff;
		nxt_sh      = sh_ff;
		nxt_tx      = tx_ff;
		nxt_ptr     = ptr_ff;
		nxt_oe      = oe_ff;
		nxt_req_tgl = req_tgl_ff;
		nxt_req     = req_ff;
		if (bus_stop) begin
			nxt_st = mrr_pkg::LK_IDLE;
			nxt_oe = 1'b0;
		end else if (bus_start) begin // RQ1
			nxt_st  = mrr_pkg::LK_ADDR;
			nxt_cnt = 4'h0;
			nxt_oe  = 1'b0;
		end else begin
			unique case (st_ff)
				mrr_pkg::LK_IDLE: begin
					nxt_oe = 1'b0; // RQ14
				end
				mrr_pkg::LK_ADDR, mrr_pkg::LK_PTR, mrr_pkg::LK_WDATA: begin
					if (scl_rise) begin // RQ3
						nxt_sh  = {sh_ff[6:0], sda_s_ff};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (scl_fall && cnt_ff == mrr_pkg::BYTE_BITS) begin
						nxt_cnt = 4'h0;
						if (st_ff == mrr_pkg::LK_ADDR) begin
							if (sh_ff[7:1] == mrr_pkg::DEV_ADDR) begin // RQ14
								nxt_oe = 1'b1;
								if (sh_ff[0]) begin
									nxt_st      = mrr_pkg::LK_RLOAD;
									nxt_req     = '{we: 1'b0, addr: ptr_ff, wdata: 8'h00};
									nxt_req_tgl = ~req_tgl_ff;
									nxt_ptr     = ptr_ff + 8'h01;
								end else begin
									nxt_st = mrr_pkg::LK_ACK_AD;
								end
							end else begin
								nxt_st = mrr_pkg::LK_IDLE;
							end
						end else if (st_ff == mrr_pkg::LK_PTR) begin
							nxt_ptr = sh_ff;
							nxt_oe  = 1'b1;
							nxt_st  = mrr_pkg::LK_ACK_PTR;
						end else begin
							nxt_req     = '{we: 1'b1, addr: ptr_ff, wdata: sh_ff};
							nxt_req_tgl = ~req_tgl_ff;
							nxt_ptr     = ptr_ff + 8'h01;
							nxt_oe      = 1'b1;
							nxt_st      = mrr_pkg::LK_ACK_WD;
						end
					end
				end
				mrr_pkg::LK_ACK_AD, mrr_pkg::LK_ACK_PTR, mrr_pkg::LK_ACK_WD: begin
					if (scl_fall) begin
						nxt_oe = 1'b0;
						nxt_st = (st_ff == mrr_pkg::LK_ACK_AD) ? mrr_pkg::LK_PTR : mrr_pkg::LK_WDATA;
					end
				end
				mrr_pkg::LK_RLOAD: begin
					if (scl_fall && rd_done) begin // RQ3
						nxt_tx  = rd_data_ff;
						nxt_oe  = ~rd_data_ff[7]; // RQ2
						nxt_cnt = 4'h1;
						nxt_st  = mrr_pkg::LK_TX;
					end
				end
				mrr_pkg::LK_TX: begin
					if (scl_fall) begin // RQ3
						if (cnt_ff == mrr_pkg::BYTE_BITS) begin
							nxt_oe  = 1'b0;
							nxt_cnt = 4'h0;
							nxt_st  = mrr_pkg::LK_MACK;
						end else begin
							nxt_tx  = {tx_ff[6:0], 1'b0};
							nxt_oe  = ~tx_ff[6]; // RQ2
							nxt_cnt = cnt_ff + 4'h1;
						end
					end
				end
				mrr_pkg::LK_MACK: begin
					if (scl_rise) begin
						if (sda_s_ff) begin
							nxt_st = mrr_pkg::LK_IDLE;
						end else begin
							nxt_req     = '{we: 1'b0, addr: ptr_ff, wdata: 8'h00};
							nxt_req_tgl = ~req_tgl_ff;
							nxt_ptr     = ptr_ff + 8'h01;
							nxt_st      = mrr_pkg::LK_RLOAD;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge link_clk) begin
		if (link_rst_ff) begin
			st_ff      <= mrr_pkg::LK_IDLE;
			cnt_ff     <= 4'h0;
			sh_ff      <= 8'h00;
			tx_ff      <= 8'h00;
			ptr_ff     <= 8'h00;
			oe_ff      <= 1'b0;
			req_tgl_ff <= 1'b0;
			req_ff     <= '0;
		end else begin
			st_ff      <= nxt_st;
			cnt_ff     <= nxt_cnt;
			sh_ff      <= nxt_sh;
			tx_ff      <= nxt_tx;
			ptr_ff     <= nxt_ptr;
			oe_ff      <= nxt_oe;
			req_tgl_ff <= nxt_req_tgl;
			req_ff     <= nxt_req;
		end
	end

	// Open drain: the level driven is always low
	assign sda_o  = 1'b0; // RQ2
	assign sda_oe = oe_ff;

	////////////////////////////////////////////////////////////////////////
	// Core domain: request crossing

	logic req_m_ff, req_s_ff, req_d_ff, req_hit;

	always_ff @(posedge ref_clk) begin
		req_m_ff <= req_tgl_ff;
		req_s_ff <= req_m_ff;
		req_d_ff <= req_s_ff;
	end

	// Payload is held by the link side until the next toggle
	assign req_hit = req_s_ff ^ req_d_ff;

	////////////////////////////////////////////////////////////////////////
	// Core domain: register file

	logic [7:0] stat_ff, nxt_stat;
	logic [2:0] pend_ff, nxt_pend;
	logic [7:0] ctl0_ff, nxt_ctl0;
	logic [7:0] rd_mux;
	logic [7:0] nxt_rd_data;
	logic       nxt_ack_tgl;
	logic       nxt_ftrig, nxt_ttrig, nxt_mdt, nxt_otp, nxt_int;
	mrr_pkg::mrr_cfg_s cfg_ff, nxt_cfg;

	always_comb begin
		unique case (req_ff.addr)
			mrr_pkg::A_XL:   rd_mux = result_i.x[7:0];   // RQ4
			mrr_pkg::A_XH:   rd_mux = result_i.x[15:8];  // RQ4
			mrr_pkg::A_YL:   rd_mux = result_i.y[7:0];   // RQ4
			mrr_pkg::A_YH:   rd_mux = result_i.y[15:8];  // RQ4
			mrr_pkg::A_ZL:   rd_mux = result_i.z[7:0];   // RQ4
			mrr_pkg::A_ZH:   rd_mux = result_i.z[15:8];  // RQ4
			mrr_pkg::A_TEMP: rd_mux = result_i.temp;     // RQ6
			mrr_pkg::A_STAT: rd_mux = stat_ff;           // RQ5
			mrr_pkg::A_CTL0: rd_mux = ctl0_ff;           // RQ5
			mrr_pkg::A_CTL1: rd_mux = cfg_ff.ctl1;       // RQ5
			mrr_pkg::A_CTL2: rd_mux = cfg_ff.ctl2;       // RQ5
			mrr_pkg::A_THX:  rd_mux = cfg_ff.thr_x;      // RQ5
			mrr_pkg::A_THY:  rd_mux = cfg_ff.thr_y;      // RQ5
			mrr_pkg::A_THZ:  rd_mux = cfg_ff.thr_z;      // RQ5
			mrr_pkg::A_PID:  rd_mux = PART_ID;           // RQ5
			default:         rd_mux = 8'h00;             // RQ17
		endcase
	end

	always_comb begin
		nxt_stat    = stat_ff;
		nxt_pend    = pend_ff;
		nxt_ctl0    = ctl0_ff;
		nxt_cfg     = cfg_ff;
		nxt_rd_data = rd_data_ff;
		nxt_ack_tgl = ack_tgl_ff;
		nxt_ftrig   = 1'b0;
		nxt_ttrig   = 1'b0;
		nxt_mdt     = 1'b0;
		nxt_otp     = 1'b0;
		if (req_hit) begin
			nxt_ack_tgl = ~ack_tgl_ff;
			if (req_ff.we) begin
				unique case (req_ff.addr)
					mrr_pkg::A_STAT: begin
						nxt_pend = pend_ff & ~req_ff.wdata[2:0]; // RQ10
						if (req_ff.wdata[mrr_pkg::ST_MOTION]) begin
							nxt_stat[mrr_pkg::ST_MOTION] = 1'b0;
						end
					end
					mrr_pkg::A_CTL0: begin
						nxt_ctl0  = req_ff.wdata & ~mrr_pkg::CT0_TRIG_MASK; // RQ16
						nxt_ftrig = req_ff.wdata[mrr_pkg::CT0_FIELD];       // RQ16
						nxt_ttrig = req_ff.wdata[mrr_pkg::CT0_TEMP];
						nxt_mdt   = req_ff.wdata[mrr_pkg::CT0_MDT];
						nxt_otp   = req_ff.wdata[mrr_pkg::CT0_OTP];
					end
					mrr_pkg::A_CTL1: nxt_cfg.ctl1  = req_ff.wdata;
					mrr_pkg::A_CTL2: nxt_cfg.ctl2  = req_ff.wdata;
					mrr_pkg::A_THX:  nxt_cfg.thr_x = req_ff.wdata;
					mrr_pkg::A_THY:  nxt_cfg.thr_y = req_ff.wdata;
					mrr_pkg::A_THZ:  nxt_cfg.thr_z = req_ff.wdata;
					default: ; // RQ17
				endcase
			end else begin
				nxt_rd_data = rd_mux;
			end
		end
		// Clears first so that a completion in the same cycle wins
		if (nxt_ftrig || nxt_ttrig) begin
			nxt_stat[mrr_pkg::ST_MDONE] = 1'b0; // RQ7
			nxt_stat[mrr_pkg::ST_TDONE] = 1'b0; // RQ8
		end
		if (nxt_otp) begin
			nxt_stat[mrr_pkg::ST_OTP] = 1'b0;
		end
		if (field_done_i) begin
			nxt_stat[mrr_pkg::ST_MDONE] = 1'b1; // RQ7
			nxt_pend[mrr_pkg::ST_MDONE] = 1'b1;
		end
		if (temp_done_i) begin
			nxt_stat[mrr_pkg::ST_TDONE] = 1'b1; // RQ8
			nxt_pend[mrr_pkg::ST_TDONE] = 1'b1;
		end
		if (motion_evt_i) begin
			nxt_stat[mrr_pkg::ST_MOTION] = 1'b1; // RQ11
			nxt_pend[mrr_pkg::ST_MOTION] = 1'b1;
		end
		if (otp_done_i) begin
			nxt_stat[mrr_pkg::ST_OTP] = 1'b1; // RQ13
		end
		nxt_stat[mrr_pkg::ST_PUMP] = pump_on_i; // RQ12
		nxt_stat[7:5]              = 3'h0;      // RQ13
		nxt_int = (|pend_ff) & cfg_ff.ctl2[mrr_pkg::CT2_INT_EN];
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stat_ff              <= mrr_pkg::ST_RESET; // RQ13
			pend_ff              <= 3'h0;
			ctl0_ff              <= mrr_pkg::CTL_RESET;
			cfg_ff               <= '0;
			rd_data_ff           <= 8'h00;
			ack_tgl_ff           <= 1'b0;
			field_sample_trigger <= 1'b0;
			temp_sample_trigger  <= 1'b0;
			motion_start         <= 1'b0;
			otp_reload           <= 1'b0;
			int_o                <= 1'b0;
		end else begin
			stat_ff              <= nxt_stat;
			pend_ff              <= nxt_pend;
			ctl0_ff              <= nxt_ctl0;
			cfg_ff               <= nxt_cfg;
			rd_data_ff           <= nxt_rd_data;
			ack_tgl_ff           <= nxt_ack_tgl;
			field_sample_trigger <= nxt_ftrig;
			temp_sample_trigger  <= nxt_ttrig;
			motion_start         <= nxt_mdt;
			otp_reload           <= nxt_otp;
			int_o                <= nxt_int; // RQ15
		end
	end

	// Pin stays released until the interrupt function is on
	assign int_oe = cfg_ff.ctl2[mrr_pkg::CT2_INT_EN]; // RQ15
	assign cfg_o  = cfg_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks

	chk_trig_self_clear: assert property (@(posedge ref_clk) disable iff (srst) // RQ16
		field_sample_trigger |=> !field_sample_trigger) else $error("trigger not self clearing");
	chk_mdone_clear: assert property (@(posedge ref_clk) disable iff (srst) // RQ7
		field_sample_trigger && !field_done_i |=> !stat_ff[0]) else $error("mag done not cleared");
	chk_mdone_set: assert property (@(posedge ref_clk) disable iff (srst) // RQ7
		field_done_i |=> stat_ff[0]) else $error("mag done not set");
	chk_tdone_set: assert property (@(posedge ref_clk) disable iff (srst) // RQ8
		temp_done_i |=> stat_ff[1]) else $error("temp done not set");
	chk_tdone_clear: assert property (@(posedge ref_clk) disable iff (srst) // RQ8
		temp_sample_trigger && !$past(temp_done_i) |-> !stat_ff[1]) else $error("temp done not cleared");
	chk_motion_flag: assert property (@(posedge ref_clk) disable iff (srst) // RQ11
		motion_evt_i |=> stat_ff[2] && pend_ff[2]) else $error("motion not flagged");
	chk_pump_follow: assert property (@(posedge ref_clk) disable iff (srst) // RQ12
		##1 stat_ff[3] == $past(pump_on_i)) else $error("pump bit stale");
	chk_rsvd_zero: assert property (@(posedge ref_clk) disable iff (srst) // RQ13
		stat_ff[7:5] == 3'h0) else $error("reserved status bits set");
	chk_int_hiz: assert property (@(posedge ref_clk) disable iff (srst) // RQ15
		!int_oe |=> !int_o) else $error("interrupt pin driven while disabled");
	chk_int_raise: assert property (@(posedge ref_clk) disable iff (srst) // RQ15
		int_oe && (|pend_ff) |=> int_o) else $error("interrupt not raised");
	chk_sda_low_clk: assert property (@(posedge link_clk) disable iff (link_rst_ff) // RQ3
		$changed(oe_ff) |-> !scl_s_ff) else $error("data line moved with clock high");
	chk_idle_quiet: assert property (@(posedge link_clk) disable iff (link_rst_ff) // RQ14
		st_ff == mrr_pkg::LK_IDLE |=> !oe_ff) else $error("driving while idle");

	cov_read: cover property (@(posedge link_clk) disable iff (link_rst_ff)
		st_ff == mrr_pkg::LK_TX ##1 st_ff == mrr_pkg::LK_MACK);
	cov_measure: cover property (@(posedge ref_clk) disable iff (srst)
		field_sample_trigger ##[1:200] stat_ff[0]);
	cov_motion_clear: cover property (@(posedge ref_clk) disable iff (srst)
		stat_ff[2] ##1 !stat_ff[2]);

endmodule

/* File: mrr_top_test.sv */
`timescale 1ns/1ps
module mrr_top_test;
	localparam logic [7:0] ID_VAL = 8'hC6; // Arbitrary identity value
	localparam int         LIMIT  = 90000;
	logic                ref_clk  = 1'b0;
	logic                link_clk = 1'b0;
	logic                srst     = 1'b1;
	logic                pump     = 1'b0;
	logic [3:0]          evt      = 4'h0;
	mrr_pkg::mrr_result_s res     = '0;
	mrr_pkg::mrr_cfg_s   cfg;
	wire  [3:0]          trg;
	logic                scl, sda, scl_pull, sda_pull, sda_o, sda_oe, int_o, int_oe;
	logic [63:0]         q;
	int                  failures = 0;
	int                  compares = 0;
	int                  cycles   = 0;
	int                  tcnt [4] = '{0, 0, 0, 0};

	always #20 ref_clk = ~ref_clk;
	always #24 link_clk = ~link_clk;
	// Open-drain wires with pull-ups
	assign scl = ~scl_pull;
	assign sda = ~(sda_pull | sda_oe);

	mrr_top #(.PART_ID(ID_VAL)) u_mrr_top (
		.ref_clk(ref_clk), .srst(srst), .link_clk(link_clk),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.int_o(int_o), .int_oe(int_oe), .result_i(res),
		.field_done_i(evt[0]), .temp_done_i(evt[1]), .motion_evt_i(evt[2]),
		.pump_on_i(pump), .otp_done_i(evt[3]),
		.field_sample_trigger(trg[0]), .temp_sample_trigger(trg[1]),
		.motion_start(trg[2]), .otp_reload(trg[3]), .cfg_o(cfg)
	);

	mrr_host u_mrr_host (.scl(scl), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull));

	always @(posedge ref_clk) begin
		for (int i = 0; i < 4; i++) begin
			tcnt[i] += (trg[i] === 1'b1) ? 1 : 0;
		end
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			close_out();
		end
	end

	task automatic close_out();
		if (failures == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic pulse(input logic [3:0] m);
		@(posedge ref_clk);
		#1 evt = m;
		@(posedge ref_clk);
		#1 evt = 4'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic k0, k1, k2;
		u_mrr_host.start_cond();
		u_mrr_host.put_byte({mrr_pkg::DEV_ADDR, 1'b0}, k0);
		u_mrr_host.put_byte(a, k1);
		u_mrr_host.put_byte(d, k2);
		u_mrr_host.stop_cond();
		chk("write ack", {k0, k1, k2}, 3'h7);
	endtask

	// Bytes land in q lowest address first
	task automatic rd(input logic [7:0] a, input int n, output logic [63:0] r);
		logic       k0, k1, k2;
		logic [7:0] b;
		r = '0;
		u_mrr_host.start_cond();
		u_mrr_host.put_byte({mrr_pkg::DEV_ADDR, 1'b0}, k0);
		u_mrr_host.put_byte(a, k1);
		u_mrr_host.stop_cond();
		u_mrr_host.start_cond();
		u_mrr_host.put_byte({mrr_pkg::DEV_ADDR, 1'b1}, k2);
		for (int i = 0; i < n; i++) begin
			u_mrr_host.get_byte(b, i == n - 1);
			r[8*i +: 8] = b;
		end
		u_mrr_host.stop_cond();
		chk("read ack", {k0, k1, k2}, 3'h7);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(mrr_pkg::A_STAT, 1, q);
		chk("status reset", q, 8'h00);
		chk("int enable", int_oe, 1'b0);
		chk("int level", int_o, 1'b0);
		chk("data out", sda_o, 1'b0);
	endtask

	task automatic t_results();
		@(posedge ref_clk);
		#1 res = {16'hA1B2, 16'hC3D4, 16'hE5F6, 8'h4C};
		pulse(4'hB);
		// Done flag is confirmed before the axis bytes are fetched
		rd(mrr_pkg::A_STAT, 1, q);
		chk("status done", q, 8'h13);
		rd(mrr_pkg::A_XL, 8, q);
		chk("result burst", q, 64'h134C_E5F6_C3D4_A1B2);
		wr(mrr_pkg::A_XL, 8'h00);
		rd(mrr_pkg::A_XL, 1, q);
		chk("result read only", q, 8'hB2);
	endtask

	task automatic t_trigger();
		wr(mrr_pkg::A_CTL0, 8'h47);
		for (int i = 0; i < 4; i++) begin
			chk("trigger pulses", tcnt[i], 1);
		end
		rd(mrr_pkg::A_STAT, 1, q);
		chk("status after trigger", q, 8'h00);
		rd(mrr_pkg::A_CTL0, 1, q);
		chk("trigger readback", q, 8'h00);
	endtask

	task automatic t_events();
		@(posedge ref_clk);
		#1 pump = 1'b1;
		pulse(4'h5);
		rd(mrr_pkg::A_STAT, 1, q);
		chk("status events", q, 8'h0D);
		chk("int released", int_oe, 1'b0);
		wr(mrr_pkg::A_CTL2, 8'h40);
		chk("int driven", int_oe, 1'b1);
		chk("int raised", int_o, 1'b1);
		wr(mrr_pkg::A_STAT, 8'h07);
		chk("int cleared", int_o, 1'b0);
		rd(mrr_pkg::A_STAT, 1, q);
		chk("status after clear", q, 8'h09);
		@(posedge ref_clk);
		#1 pump = 1'b0;
		rd(mrr_pkg::A_STAT, 1, q);
		chk("pump off", q, 8'h01);
	endtask

	task automatic t_config();
		wr(mrr_pkg::A_CTL1, 8'h15);
		wr(mrr_pkg::A_THX, 8'h2A);
		wr(mrr_pkg::A_THY, 8'h3B);
		wr(mrr_pkg::A_THZ, 8'h4C);
		rd(mrr_pkg::A_CTL1, 5, q);
		chk("config burst", q, 64'h0000_004C_3B2A_4015);
		chk("config port", cfg, {8'h15, 8'h40, 8'h2A, 8'h3B, 8'h4C});
		rd(mrr_pkg::A_PID, 1, q);
		chk("part id", q, ID_VAL);
		wr(8'h20, 8'hFF);
		rd(8'h20, 1, q);
		chk("unmapped", q, 8'h00);
		rd(8'h0E, 1, q);
		chk("unmapped gap", q, 8'h00);
	endtask

	task automatic t_foreign();
		logic k;
		u_mrr_host.start_cond();
		u_mrr_host.put_byte({7'h31, 1'b0}, k);
		u_mrr_host.stop_cond();
		chk("foreign ack", k, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Two core cycles always cover a link edge, enough for the two-flop reset crossing
	initial begin
		repeat (2) @(posedge ref_clk);
		#1 srst = 1'b0;
		repeat (10) @(posedge ref_clk);
		t_reset();
		t_results();
		t_trigger();
		t_events();
		t_config();
		t_foreign();
		close_out();
	end
endmodule
